// ===== rtl/period_timer.sv
`timescale 1ns/100ps

// Down counter: load starts a period, done pulses when it has run out.
module period_timer (
	// Clock and reset
	input  wire logic                         mclk,
	input  wire logic                         rst,
	// Control
	input  wire logic                         load,
	input  wire logic [rst_ctrl_pkg::CNT_W-1:0] count,
	// Status
	output logic                              busy,
	output logic                              done
);

	logic [rst_ctrl_pkg::CNT_W-1:0] cnt_q;
	logic [rst_ctrl_pkg::CNT_W-1:0] cnt_d;
	logic                           done_q;
	logic                           done_d;

	always_comb begin
		cnt_d  = cnt_q;
		done_d = 1'b0;
		if (load) begin
			cnt_d = count;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
			done_d = (cnt_q == {{(rst_ctrl_pkg::CNT_W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign busy = (cnt_q != '0);
	assign done = done_q;

endmodule : period_timer

// ===== rtl/rst_ctrl_pkg.sv
package rst_ctrl_pkg;

	// ---------------------------------------------------------------
	// Clock and reset periods
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 200_000_000;
	localparam int unsigned POR_TIME_US  = 100_000;
	localparam int unsigned SWR_TIME_US  = 250;
	localparam int unsigned POR_CYCLES   = POR_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned SWR_CYCLES   = SWR_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W        = 25;

	// ---------------------------------------------------------------
	// Command decoding
	// ---------------------------------------------------------------
	localparam logic [15:0] CMD_SW_RESET   = 16'hFE00;
	localparam logic [15:0] CMD_FIFO_MASK  = 16'hFF00;
	localparam logic [15:0] CMD_FIFO_MODE  = 16'hCA00;
	localparam int unsigned MODE_BIT       = 0;

	// ---------------------------------------------------------------
	// Reset values and state codes
	// ---------------------------------------------------------------
	localparam logic        NORMAL_RST_VAL = 1'b0;

	typedef enum logic [2:0] {
		ST_POR = 3'h1,
		ST_SWR = 3'h2,
		ST_RUN = 3'h4
	} rst_state_t;

	typedef enum logic [1:0] {
		CAUSE_POR    = 2'h0,
		CAUSE_GLITCH = 2'h1,
		CAUSE_SW     = 2'h2
	} rst_cause_t;

endpackage : rst_ctrl_pkg

// ===== rtl/transceiver_reset_control.sv
`timescale 1ns/100ps

// Overview of operation
// (R1) Power-on, glitch or command all cause reset.
// (R2) Commands ignored during 100 ms power-on reset.
// (R3) Leave reset in sensitive mode.
// (R4) Mode command bit zero selects normal mode.
// (R5) Normal mode disables glitch detection.
// (R6) Sensitive mode: fast rise over threshold resets.
// (R7) Falling supply resets only below low threshold.
// (R8) Every reset restores defaults, sensitive mode.
// (R9) Software reset like power-on, 0.25 ms long.
// (R10) Software reset acts only in sensitive mode.
// (R11) Command FE00h starts software reset.
// (R12) Release synchronously; accept commands only afterwards.
module transceiver_reset_control #(
	parameter int unsigned POR_CYCLES = rst_ctrl_pkg::POR_CYCLES,
	parameter int unsigned SWR_CYCLES = rst_ctrl_pkg::SWR_CYCLES
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Supply detector inputs
	input  wire logic        fast_rise,
	input  wire logic        ramp_over_thr,
	input  wire logic        below_low_normal,
	input  wire logic        below_low_sens,
	// Decoded serial command
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_word,
	// Status and reset outputs
	output logic             chip_rst,
	output logic             cmd_accept,
	output logic             normal_mode,
	output logic             cmd_taken,
	output logic [1:0]       last_cause
);

	// ---------------------------------------------------------------
	// Reset causes
	// ---------------------------------------------------------------
	rst_ctrl_pkg::rst_state_t state_q;
	rst_ctrl_pkg::rst_state_t state_d;
	logic                     normal_q;
	logic                     normal_d;
	logic                     chip_rst_q;
	logic                     chip_rst_d;
	logic                     accept_q;
	logic                     accept_d;
	logic                     taken_q;
	logic                     taken_d;
	logic [1:0]               cause_q;
	logic [1:0]               cause_d;
	logic                     tmr_load;
	logic [rst_ctrl_pkg::CNT_W-1:0] tmr_count;
	logic                     tmr_busy;
	logic                     tmr_done;
	logic                     low_supply;
	logic                     glitch;
	logic                     running;
	logic                     cmd_ok;
	logic                     sw_req;
	logic                     mode_wr;

	// The low threshold follows the mode: 250 mV normal, 1.6 V sensitive.
	assign low_supply = normal_q ? below_low_normal : below_low_sens; // R7
	// Glitch path is gated off entirely in normal mode.
	assign glitch  = !normal_q && fast_rise && ramp_over_thr; // R5 R6
	assign running = (state_q == rst_ctrl_pkg::ST_RUN);
	assign cmd_ok  = running && cmd_valid; // R2 R12
	assign sw_req  = cmd_ok && (cmd_word == rst_ctrl_pkg::CMD_SW_RESET)
		&& !normal_q; // R10 R11
	assign mode_wr = cmd_ok && ((cmd_word & rst_ctrl_pkg::CMD_FIFO_MASK)
		== rst_ctrl_pkg::CMD_FIFO_MODE);

	// ---------------------------------------------------------------
	// Reset sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_d    = state_q;
		normal_d   = normal_q;
		chip_rst_d = chip_rst_q;
		accept_d   = accept_q;
		taken_d    = 1'b0;
		cause_d    = cause_q;
		tmr_load   = 1'b0;
		tmr_count  = rst_ctrl_pkg::CNT_W'(POR_CYCLES);
		if (low_supply || glitch) begin // R1 R6 R7
			state_d    = rst_ctrl_pkg::ST_POR;
			normal_d   = rst_ctrl_pkg::NORMAL_RST_VAL; // R8
			chip_rst_d = 1'b1;
			accept_d   = 1'b0;
			tmr_load   = 1'b1;
			cause_d    = glitch ? 2'(rst_ctrl_pkg::CAUSE_GLITCH)
				: 2'(rst_ctrl_pkg::CAUSE_POR);
		end else begin
			case (state_q)
				rst_ctrl_pkg::ST_POR,
				rst_ctrl_pkg::ST_SWR: begin
					// Commands are dropped until the period ends.
					if (tmr_done) begin // R12
						state_d    = rst_ctrl_pkg::ST_RUN;
						chip_rst_d = 1'b0;
						accept_d   = 1'b1;
					end
				end
				rst_ctrl_pkg::ST_RUN: begin
					if (sw_req) begin // R1 R9 R11
						state_d    = rst_ctrl_pkg::ST_SWR;
						normal_d   = rst_ctrl_pkg::NORMAL_RST_VAL; // R8
						chip_rst_d = 1'b1;
						accept_d   = 1'b0;
						taken_d    = 1'b1;
						tmr_load   = 1'b1;
						tmr_count  = rst_ctrl_pkg::CNT_W'(SWR_CYCLES); // R9
						cause_d    = 2'(rst_ctrl_pkg::CAUSE_SW);
					end else if (mode_wr) begin
						// Only bit zero matters; writing zero is not a way back.
						if (cmd_word[rst_ctrl_pkg::MODE_BIT]) begin // R4
							normal_d = 1'b1;
						end
						taken_d = 1'b1;
					end else if (cmd_ok) begin
						taken_d = 1'b1;
					end
				end
				default: begin
					state_d = rst_ctrl_pkg::ST_POR;
				end
			endcase
		end
	end

	// Reset starts a full power-on period in sensitive mode.
	always_ff @(posedge mclk) begin
		if (rst) begin // R1 R3
			state_q    <= rst_ctrl_pkg::ST_POR;
			normal_q   <= rst_ctrl_pkg::NORMAL_RST_VAL;
			chip_rst_q <= 1'b1;
			accept_q   <= 1'b0;
			taken_q    <= 1'b0;
			cause_q    <= 2'(rst_ctrl_pkg::CAUSE_POR);
		end else begin
			state_q    <= state_d;
			normal_q   <= normal_d;
			chip_rst_q <= chip_rst_d;
			accept_q   <= accept_d;
			taken_q    <= taken_d;
			cause_q    <= cause_d;
		end
	end

	// A power-on reset also arms the timer, so reset loads it too.
	period_timer u_timer (
		.mclk  (mclk),
		.rst   (1'b0),
		.load  (tmr_load || rst),
		.count (tmr_count),
		.busy  (tmr_busy),
		.done  (tmr_done)
	);

	assign chip_rst    = chip_rst_q;
	assign cmd_accept  = accept_q;
	assign normal_mode = normal_q;
	assign cmd_taken   = taken_q;
	assign last_cause  = cause_q;

	// ---------------------------------------------------------------
	// Period length monitor
	// ---------------------------------------------------------------
	// Counts the cycles with chip reset held since the timer was last armed, so the checks can
	// hold each release against its period without a long repetition.
	// It saturates, so a stuck reset cannot wrap it back into range.
	logic [rst_ctrl_pkg::CNT_W-1:0] held_q;
	logic [rst_ctrl_pkg::CNT_W-1:0] held_d;
	logic                           sw_period_q;
	logic                           sw_period_d;

	always_comb begin
		held_d      = held_q;
		sw_period_d = sw_period_q;
		if (tmr_load || rst) begin
			held_d      = '0;
			sw_period_d = !rst && sw_req && !low_supply && !glitch;
		end else if (chip_rst_q && (held_q != '1)) begin
			held_d = held_q + 1'b1;
		end
	end

	// The clear above covers reset, so this register needs no branch.
	always_ff @(posedge mclk) begin
		held_q      <= held_d;
		sw_period_q <= sw_period_d;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sw_only_sens_a: assert property (@(posedge mclk) disable iff (rst) // R10
		(running && cmd_valid && cmd_word == rst_ctrl_pkg::CMD_SW_RESET
		&& normal_q && !low_supply) |=> !chip_rst)
		else $error("software reset acted in normal mode");
	sw_reset_go_a: assert property (@(posedge mclk) disable iff (rst) // R11
		(sw_req && !low_supply && !glitch) |=> chip_rst && cmd_taken
		&& last_cause == 2'(rst_ctrl_pkg::CAUSE_SW))
		else $error("software reset not started");
	glitch_gate_a: assert property (@(posedge mclk) disable iff (rst) // R5
		(normal_q && fast_rise && ramp_over_thr && !below_low_normal
		&& running) |=> !chip_rst)
		else $error("glitch reset in normal mode");
	glitch_rst_a: assert property (@(posedge mclk) disable iff (rst) // R6
		(!normal_q && fast_rise && ramp_over_thr) |=> chip_rst && !cmd_accept)
		else $error("glitch did not reset");
	low_rst_a: assert property (@(posedge mclk) disable iff (rst) // R7
		low_supply |=> chip_rst && !normal_mode)
		else $error("low supply did not reset");
	mode_def_a: assert property (@(posedge mclk) disable iff (rst) // R8
		$rose(chip_rst) |-> !normal_mode)
		else $error("reset kept normal mode");
	mode_set_a: assert property (@(posedge mclk) disable iff (rst) // R4
		(mode_wr && cmd_word[0] && !sw_req && !low_supply && !glitch)
		|=> normal_mode)
		else $error("mode command ignored");
	no_cmd_rst_a: assert property (@(posedge mclk) disable iff (rst) // R2
		chip_rst |-> !cmd_accept ##1 !cmd_taken)
		else $error("command taken during reset");
	release_a: assert property (@(posedge mclk) disable iff (rst) // R12
		$fell(chip_rst) |-> cmd_accept && !normal_mode && $past(tmr_done))
		else $error("release not timed");
	sw_len_a: assert property (@(posedge mclk) disable iff (rst) // R9
		(state_q == rst_ctrl_pkg::ST_SWR && tmr_busy) |-> chip_rst)
		else $error("software reset ended early");
	// Release timing against the period that was armed last.
	sw_period_a: assert property (@(posedge mclk) disable iff (rst) // R9
		($fell(chip_rst) && sw_period_q)
		|-> held_q == rst_ctrl_pkg::CNT_W'(SWR_CYCLES + 1))
		else $error("software reset has wrong length");
	por_period_a: assert property (@(posedge mclk) disable iff (rst) // R2
		($fell(chip_rst) && !sw_period_q)
		|-> held_q == rst_ctrl_pkg::CNT_W'(POR_CYCLES + 1))
		else $error("power-on reset has wrong length");
	retrigger_a: assert property (@(posedge mclk) disable iff (rst) // R6
		(low_supply || glitch) |=> held_q == '0
		&& state_q == rst_ctrl_pkg::ST_POR)
		else $error("reset period not restarted");
	// Commands and the accept flag.
	por_cmd_drop_a: assert property (@(posedge mclk) disable iff (rst) // R2
		(state_q == rst_ctrl_pkg::ST_POR && cmd_valid) |=> !cmd_taken)
		else $error("command taken in power-on reset");
	cmd_ignore_a: assert property (@(posedge mclk) disable iff (rst) // R12
		(state_q == rst_ctrl_pkg::ST_SWR && cmd_valid) |=> !cmd_taken)
		else $error("command taken in software reset");
	taken_src_a: assert property (@(posedge mclk) disable iff (rst) // R12
		cmd_taken |-> $past(cmd_ok))
		else $error("command taken from nowhere");
	accept_flag_a: assert property (@(posedge mclk) disable iff (rst) // R12
		cmd_accept != chip_rst)
		else $error("accept flag disagrees with reset");
	rst_default_a: assert property (@(posedge mclk) disable iff (rst) // R3
		$fell(rst) |-> chip_rst && !normal_mode && !cmd_accept)
		else $error("reset did not restore defaults");
	state_onehot_a: assert property (@(posedge mclk) disable iff (rst) // R1
		$onehot(state_q))
		else $error("sequencer state not one-hot");
	// Cause codes and the mode-dependent thresholds.
	cause_glitch_a: assert property (@(posedge mclk) disable iff (rst) // R1
		glitch |=> chip_rst
		&& last_cause == 2'(rst_ctrl_pkg::CAUSE_GLITCH))
		else $error("glitch cause not recorded");
	cause_low_a: assert property (@(posedge mclk) disable iff (rst) // R1
		(low_supply && !glitch)
		|=> last_cause == 2'(rst_ctrl_pkg::CAUSE_POR))
		else $error("low supply cause not recorded");
	sw_state_a: assert property (@(posedge mclk) disable iff (rst) // R9
		(state_q == rst_ctrl_pkg::ST_SWR)
		|-> last_cause == 2'(rst_ctrl_pkg::CAUSE_SW))
		else $error("software period with wrong cause");
	mode_hold_a: assert property (@(posedge mclk) disable iff (rst) // R4
		(normal_mode && !low_supply) |=> normal_mode)
		else $error("normal mode lost without reset");
	timer_arm_a: assert property (@(posedge mclk) disable iff (rst) // R9
		$rose(chip_rst) |-> tmr_busy)
		else $error("reset without a running period");
	low_norm_a: assert property (@(posedge mclk) disable iff (rst) // R7
		(normal_q && running && !below_low_normal) |=> !chip_rst)
		else $error("reset above normal low threshold");
	sens_low_a: assert property (@(posedge mclk) disable iff (rst) // R7
		(!normal_q && below_low_sens) |=> chip_rst)
		else $error("no reset below sensitive threshold");

	sw_seen_c: cover property (@(posedge mclk) disable iff (rst)
		sw_req ##[1:1000] $fell(chip_rst));
	mode_seen_c: cover property (@(posedge mclk) disable iff (rst)
		$rose(normal_mode));
	glitch_seen_c: cover property (@(posedge mclk) disable iff (rst)
		glitch && running);
	normal_sw_c: cover property (@(posedge mclk) disable iff (rst)
		running && cmd_valid && normal_q
		&& cmd_word == rst_ctrl_pkg::CMD_SW_RESET);
	low_seen_c: cover property (@(posedge mclk) disable iff (rst)
		low_supply && running);

endmodule : transceiver_reset_control

// ===== tb/host_model.sv
`timescale 1ns/100ps

// -----------------------------
// Host command source
// -----------------------------
module host_model (
	// Clock
	input  wire logic mclk,
	// Command output
	output logic        cmd_valid,
	output logic [15:0] cmd_word
);
	initial begin
		cmd_valid = 1'b0;
		cmd_word  = 16'h0000;
	end

	// The word is inverted once released, so a stale value is never read.
	task automatic send(input logic [15:0] w);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_word  <= w;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_word  <= ~w;
	endtask : send
endmodule : host_model

// ===== tb/testbench.sv
`timescale 1ns/100ps

module testbench;
	localparam int POR_C = 20;
	localparam int SWR_C = 8;
	logic        mclk;
	logic        rst;
	logic        fast_rise;
	logic        ramp_over_thr;
	logic        below_low_normal;
	logic        below_low_sens;
	logic        cmd_valid;
	logic [15:0] cmd_word;
	logic        chip_rst;
	logic        cmd_accept;
	logic        normal_mode;
	logic        cmd_taken;
	logic [1:0]  last_cause;
	int          fail_count;
	int          checks_done;
	int          n;

	host_model host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));

	transceiver_reset_control #(.POR_CYCLES(POR_C), .SWR_CYCLES(SWR_C)) dut (
		.mclk(mclk), .rst(rst), .fast_rise(fast_rise),
		.ramp_over_thr(ramp_over_thr), .below_low_normal(below_low_normal),
		.below_low_sens(below_low_sens), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word), .chip_rst(chip_rst), .cmd_accept(cmd_accept),
		.normal_mode(normal_mode), .cmd_taken(cmd_taken),
		.last_cause(last_cause));

	// -----------------------------
	// Shared tasks
	// -----------------------------
	task automatic chk(input logic c, input string m);
		checks_done++;
		if (c !== 1'b1) begin
			fail_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// Counts edges until commands are taken again, within a window.
	task automatic wait_run(input int lo, input int hi);
		n = 0;
		while (cmd_accept !== 1'b1) begin
			@(posedge mclk);
			#1;
			n++;
			if (n > 200) begin
				fail_count++;
				$display("BAD %0t hang", $time);
				give_verdict();
			end
		end
		chk(n >= lo && n <= hi, "release time");
		chk(chip_rst === 1'b0, "reset held");
	endtask : wait_run

	// Holds a detector pattern for one edge: rise, ramp, low_n, low_s.
	task automatic det(input logic [3:0] v);
		@(posedge mclk);
		{fast_rise, ramp_over_thr, below_low_normal, below_low_sens} <= v;
		@(posedge mclk);
		{fast_rise, ramp_over_thr, below_low_normal, below_low_sens} <= 4'h0;
		#1;
	endtask : det

	// -----------------------------
	// Scenarios
	// -----------------------------
	task automatic t_por();
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		host.send(16'hFE00);
		#1;
		chk(cmd_taken === 1'b0 && last_cause === 2'h0, "cmd in por");
		wait_run(POR_C - 4, POR_C + 4);
		chk(normal_mode === 1'b0, "mode after por");
		$display("test por done");
	endtask : t_por

	task automatic t_swr();
		host.send(16'hFE00);
		#1;
		chk(chip_rst === 1'b1 && last_cause === 2'h2, "sw reset");
		chk(cmd_taken === 1'b1, "taken");
		host.send(16'hCA01);
		wait_run(SWR_C - 4, SWR_C + 1);
		chk(normal_mode === 1'b0, "cmd in reset");
		$display("test swr done");
	endtask : t_swr

	task automatic t_mode();
		host.send(16'hCA01);
		@(posedge mclk);
		#1;
		chk(normal_mode === 1'b1, "mode set");
		host.send(16'hFE00);
		#1;
		chk(chip_rst === 1'b0 && cmd_taken === 1'b1, "sw normal");
		det(4'hC);
		chk(chip_rst === 1'b0, "glitch normal");
		det(4'h1);
		chk(chip_rst === 1'b0, "sens low normal");
		det(4'h2);
		chk(chip_rst === 1'b1 && normal_mode === 1'b0, "low supply");
		wait_run(POR_C - 4, POR_C + 4);
		$display("test mode done");
	endtask : t_mode

	task automatic t_glitch();
		det(4'h8);
		chk(chip_rst === 1'b0, "rise only");
		det(4'hC);
		chk(chip_rst === 1'b1 && last_cause === 2'h1, "glitch");
		wait_run(POR_C - 4, POR_C + 4);
		det(4'h1);
		chk(chip_rst === 1'b1 && last_cause === 2'h0, "sens low");
		wait_run(POR_C - 4, POR_C + 4);
		$display("test glitch done");
	endtask : t_glitch

	// A zero mode bit must not undo normal mode; a reset in mid-run must.
	task automatic t_rst();
		host.send(16'hCA01);
		host.send(16'hCA00);
		@(posedge mclk);
		#1;
		chk(normal_mode === 1'b1 && cmd_taken === 1'b0, "zero bit");
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk(chip_rst === 1'b1 && normal_mode === 1'b0, "mid reset");
		chk(cmd_accept === 1'b0 && last_cause === 2'h0, "mid cause");
		wait_run(POR_C - 4, POR_C + 4);
		chk(normal_mode === 1'b0, "mode after reset");
		$display("test rst done");
	endtask : t_rst

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		fail_count = 0;
		checks_done = 0;
		rst = 1'b1;
		{fast_rise, ramp_over_thr, below_low_normal, below_low_sens} = 4'h0;
		t_por();
		t_swr();
		t_mode();
		t_glitch();
		t_rst();
		give_verdict();
	end
endmodule : testbench
